// >>> scl_map.svh
// Register offsets, field positions, reset values and key words of the config bank.
// Notes on behaviour
// - Setting the bus error exception disable bit suppresses bus matrix error exceptions.
// - Unmapped addresses answer normally without any error and read as an all-zero word.
// - Arbitration mode 00 is fixed with CPU highest, 01 fixed CPU lowest, 10 round robin.
// - Executable RAM starts at the RAM base plus the start field times one kilobyte.
// - The scan port enable bit switches the JTAG port and resets from the strapped setting.
// - Unused config control bits read as zero and the two lowest reserved bits read as one.
// - The identification word is read-only with a 4-bit revision over a 28-bit part code.
// - Writing the first then the second key word to the unlock register unlocks the system.
// - Unlock register bit zero reads the unlocked state, resets to one, other bits write-only.
// - The band gap register has clear, set and invert aliases at plus 4, 8 and 12.
// - The band gap register resets to zero and holds only bits 2 and 1.
// - Bit 2 turns on the converter reference and bit 1 the comparator reference.
// - Hardware may set and clear both band gap enable bits as well as software.
`ifndef SCL_MAP_SVH
`define SCL_MAP_SVH
`define SCL_ADDR_W 16
`define SCL_OFS_CFG 16'h3640
`define SCL_OFS_PART_IDENT_FIELD 16'h3660
`define SCL_OFS_KEY 16'h3670
`define SCL_OFS_BG 16'h2300
`define SCL_OFS_BG_CLR 16'h2304
`define SCL_OFS_BG_SET 16'h2308
`define SCL_OFS_BG_INV 16'h230C
`define SCL_OFS_IRQ_STAT 16'h3680
`define SCL_OFS_IRQ_MASK 16'h3684
`define SCL_CFG_ERRDIS_BIT 27
`define SCL_CFG_ARB_HI 25
`define SCL_CFG_ARB_LO 24
`define SCL_CFG_EXEC_HI 23
`define SCL_CFG_EXEC_LO 16
`define SCL_CFG_SCAN_BIT 3
`define SCL_CFG_RSVD_ONES 32'h0000_0003
`define SCL_ARB_CPU_HIGH 2'h0
`define SCL_ARB_CPU_LOW 2'h1
`define SCL_ARB_ROUND_ROBIN 2'h2
`define SCL_RAM_BASE 32'hA000_0000
`define SCL_EXEC_SHIFT 10
`define SCL_KEY_FIRST 32'hAA99_6655
`define SCL_KEY_SECOND 32'h5566_99AA
`define SCL_BG_ADC_BIT 2
`define SCL_BG_CMP_BIT 1
`define SCL_BG_LO 1
`define SCL_BG_HI 2
`define SCL_REV_DEFAULT 4'h1
`define SCL_PART_DEFAULT 28'h000_0C5A
`define SCL_EV_W 3
`define SCL_EV_UNLOCK 0
`define SCL_EV_KEY_FAIL 1
`define SCL_EV_BLOCKED 2
`define SCL_INIT_LOAD 2'h3
`define SCL_ZERO 32'h0000_0000
`define SCL_FULL_BE 4'hF
`endif

// >>> scl_pkg.sv
// Types shared by the config bank modules.
`default_nettype none
`include "scl_map.svh"
package scl_pkg;
  // Unlock sequence states; code 2'b11 is illegal.
  typedef enum logic [1:0] {
    SCL_LOCKED = 2'b00,
    SCL_KEY1_SEEN = 2'b01,
    SCL_UNLOCKED = 2'b10
  } scl_lock_t;

  // Whole state of the register bank.
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic err_dis;
    logic [1:0] arb;
    logic [7:0] exec;
    logic scan_en;
    logic [1:0] init_cnt;
    logic strap_meta;
    logic strap_sync;
    scl_lock_t lock;
    logic [1:0] bg;
    logic [`SCL_EV_W-1:0] mask;
    logic exc;
  } scl_state_t;
endpackage
`default_nettype wire

// >>> scl_sticky.sv
// Sticky event bits with write-one-to-clear and a masked level interrupt.
`timescale 1ns/1ns
`default_nettype none
module scl_sticky #(
  parameter int W = 3
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [W-1:0] set_i,
  input wire logic [W-1:0] clr_i,
  input wire logic [W-1:0] mask_i,
  output logic [W-1:0] status_o,
  output logic irq_o
);
  typedef struct packed {
    logic [W-1:0] stat;
  } scl_sticky_st_t;

  scl_sticky_st_t st;
  scl_sticky_st_t next_st;

  // A set in the same cycle as its clear wins, so no event is lost.
  always_comb begin
    next_st = st;
    next_st.stat = (st.stat & ~clr_i) | set_i;
  end

  // State register.
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign status_o = st.stat;
  assign irq_o = |(st.stat & mask_i);
endmodule
`default_nettype wire

// >>> scl_regs.sv
// System configuration, identification, unlock key and band gap register bank.
//
// The Avalon-MM interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "scl_map.svh"
module scl_regs import scl_pkg::*; #(
  parameter logic [3:0] REV_ID = `SCL_REV_DEFAULT,
  parameter logic [27:0] PART_ID = `SCL_PART_DEFAULT
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [`SCL_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o,
  input wire logic bus_matrix_err_i,
  output logic bus_error_exc_o,
  output logic [1:0] arbitration_mode_sel_o,
  output logic arb_fixed_cpu_high_o,
  output logic arb_fixed_cpu_low_o,
  output logic arb_round_robin_o,
  output logic [31:0] ram_exec_start_addr_o,
  output logic ram_exec_all_o,
  input wire logic scan_port_cfg_i,
  output logic scan_port_enable_o,
  output logic system_unlocked_o,
  input wire logic [1:0] bg_hw_set_i,
  input wire logic [1:0] bg_hw_clr_i,
  output logic converter_ref_enable_o,
  output logic comparator_ref_enable_o
);
  // Reset image of the whole bank; the system starts unlocked.
  localparam scl_state_t ST_RST = '{
    ack: 1'b0,
    rdata: `SCL_ZERO,
    err_dis: 1'b0,
    arb: `SCL_ARB_CPU_HIGH,
    exec: 8'h00,
    scan_en: 1'b0,
    init_cnt: 2'h0,
    strap_meta: 1'b0,
    strap_sync: 1'b0,
    lock: SCL_UNLOCKED,
    bg: 2'h0,
    mask: '0,
    exc: 1'b0
  };

  scl_state_t st;
  scl_state_t next_st;
  logic [`SCL_EV_W-1:0] ev;
  logic [`SCL_EV_W-1:0] ev_clr;
  logic [`SCL_EV_W-1:0] ev_stat;

  // Expands the byte enables into a bit mask.
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return m;
  endfunction

  // Packs the config control fields into their register image.
  function automatic logic [31:0] cfg_word(input scl_state_t s);
    logic [31:0] w;
    w = `SCL_CFG_RSVD_ONES;
    w[`SCL_CFG_ERRDIS_BIT] = s.err_dis;
    w[`SCL_CFG_ARB_HI:`SCL_CFG_ARB_LO] = s.arb;
    w[`SCL_CFG_EXEC_HI:`SCL_CFG_EXEC_LO] = s.exec;
    w[`SCL_CFG_SCAN_BIT] = s.scan_en;
    return w;
  endfunction

  // Packs the band gap enables into their register image.
  function automatic logic [31:0] bg_word(input logic [1:0] bg);
    logic [31:0] w;
    w = `SCL_ZERO;
    w[`SCL_BG_HI:`SCL_BG_LO] = bg;
    return w;
  endfunction

  // Main next-state logic: bus slave, config fields, key sequence, band gap.
  always_comb begin
    logic busy;
    logic req;
    logic done;
    logic wr;
    logic [31:0] m;
    logic [31:0] wd;
    logic [31:0] rd;
    logic [31:0] merged;
    logic [1:0] bg_bits;
    logic unlocked;
    logic key_wr;
    busy = 1'b0;
    req = 1'b0;
    done = 1'b0;
    wr = 1'b0;
    m = `SCL_ZERO;
    wd = `SCL_ZERO;
    rd = `SCL_ZERO;
    merged = `SCL_ZERO;
    bg_bits = 2'h0;
    unlocked = 1'b0;
    key_wr = 1'b0;
    next_st = st;
    ev = '0;
    ev_clr = '0;

    // One wait cycle per access: data is looked up, then the access completes.
    busy = avs_read_i | avs_write_i;
    req = busy & ~st.ack;
    done = busy & st.ack;
    next_st.ack = req;
    wr = avs_write_i & done;
    m = be_mask(avs_byteenable_i);
    wd = avs_writedata_i & m;
    unlocked = (st.lock == SCL_UNLOCKED);

    // Read lookup; any address not decoded here returns zero without error.
    if (req) begin
      case (avs_address_i)
        `SCL_OFS_CFG: rd = cfg_word(st);
        `SCL_OFS_PART_IDENT_FIELD: rd = {REV_ID, PART_ID};
        `SCL_OFS_KEY: rd = {31'h0000_0000, unlocked};
        `SCL_OFS_BG: rd = bg_word(st.bg);
        `SCL_OFS_IRQ_STAT: rd = {{(32-`SCL_EV_W){1'b0}}, ev_stat};
        `SCL_OFS_IRQ_MASK: rd = {{(32-`SCL_EV_W){1'b0}}, st.mask};
        default: rd = `SCL_ZERO;
      endcase
      next_st.rdata = rd;
    end

    // Config control writes only land while the system is unlocked.
    if (wr && avs_address_i == `SCL_OFS_CFG) begin
      if (unlocked) begin
        merged = (cfg_word(st) & ~m) | wd;
        next_st.err_dis = merged[`SCL_CFG_ERRDIS_BIT];
        next_st.arb = merged[`SCL_CFG_ARB_HI:`SCL_CFG_ARB_LO];
        next_st.exec = merged[`SCL_CFG_EXEC_HI:`SCL_CFG_EXEC_LO];
        next_st.scan_en = merged[`SCL_CFG_SCAN_BIT];
      end else begin
        ev[`SCL_EV_BLOCKED] = 1'b1;
      end
    end

    // Unlock sequence; a partial word write can never match a key.
    key_wr = wr && avs_address_i == `SCL_OFS_KEY;
    if (key_wr) begin
      unique case (st.lock)
        SCL_LOCKED: begin
          if (avs_byteenable_i == `SCL_FULL_BE && avs_writedata_i == `SCL_KEY_FIRST) begin
            next_st.lock = SCL_KEY1_SEEN;
          end else begin
            next_st.lock = SCL_LOCKED;
            ev[`SCL_EV_KEY_FAIL] = 1'b1;
          end
        end
        SCL_KEY1_SEEN: begin
          if (avs_byteenable_i == `SCL_FULL_BE && avs_writedata_i == `SCL_KEY_SECOND) begin
            next_st.lock = SCL_UNLOCKED;
            ev[`SCL_EV_UNLOCK] = 1'b1;
          end else begin
            next_st.lock = SCL_LOCKED;
            ev[`SCL_EV_KEY_FAIL] = 1'b1;
          end
        end
        SCL_UNLOCKED: begin
          // Any write while unlocked locks again; the first key also starts over.
          if (avs_byteenable_i == `SCL_FULL_BE && avs_writedata_i == `SCL_KEY_FIRST) begin
            next_st.lock = SCL_KEY1_SEEN;
          end else begin
            next_st.lock = SCL_LOCKED;
          end
        end
        default: next_st.lock = SCL_LOCKED;
      endcase
    end

    // Band gap register and its clear, set and invert aliases.
    bg_bits = wd[`SCL_BG_HI:`SCL_BG_LO];
    if (wr) begin
      case (avs_address_i)
        `SCL_OFS_BG: begin
          if (avs_byteenable_i[0]) begin
            next_st.bg = bg_bits;
          end
        end
        `SCL_OFS_BG_CLR: next_st.bg = st.bg & ~bg_bits;
        `SCL_OFS_BG_SET: next_st.bg = st.bg | bg_bits;
        `SCL_OFS_BG_INV: next_st.bg = st.bg ^ bg_bits;
        default: next_st.bg = st.bg;
      endcase
    end
    // Hardware clear, then hardware set, so a hardware set always wins.
    next_st.bg = (next_st.bg & ~bg_hw_clr_i) | bg_hw_set_i;

    // Interrupt mask and write-one-to-clear status.
    if (wr && avs_address_i == `SCL_OFS_IRQ_MASK) begin
      next_st.mask = (st.mask & ~m[`SCL_EV_W-1:0]) | wd[`SCL_EV_W-1:0];
    end
    if (wr && avs_address_i == `SCL_OFS_IRQ_STAT) begin
      ev_clr = wd[`SCL_EV_W-1:0];
    end

    // Strap capture: two synchroniser stages, then the scan enable is loaded once.
    next_st.strap_meta = scan_port_cfg_i;
    next_st.strap_sync = st.strap_meta;
    if (st.init_cnt != `SCL_INIT_LOAD) begin
      next_st.init_cnt = st.init_cnt + 2'h1;
      if (st.init_cnt + 2'h1 == `SCL_INIT_LOAD) begin
        next_st.scan_en = st.strap_sync;
      end
    end

    // Bus matrix errors raise an exception unless suppressed.
    next_st.exc = bus_matrix_err_i & ~st.err_dis;
  end

  // State register.
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  // Sticky event status and the masked interrupt line.
  scl_sticky #(
    .W(`SCL_EV_W)
  ) u_events (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .set_i(ev),
    .clr_i(ev_clr),
    .mask_i(st.mask),
    .status_o(ev_stat),
    .irq_o(irq_o)
  );

  // Bus answers.
  assign avs_readdata_o = st.rdata;
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~st.ack;

  // Bus matrix controls.
  assign bus_error_exc_o = st.exc;
  assign arbitration_mode_sel_o = st.arb;
  assign arb_fixed_cpu_high_o = (st.arb == `SCL_ARB_CPU_HIGH);
  assign arb_fixed_cpu_low_o = (st.arb == `SCL_ARB_CPU_LOW);
  assign arb_round_robin_o = (st.arb == `SCL_ARB_ROUND_ROBIN);

  // Executable RAM start address.
  assign ram_exec_start_addr_o = `SCL_RAM_BASE + ({24'h00_0000, st.exec} << `SCL_EXEC_SHIFT);
  assign ram_exec_all_o = (st.exec == 8'h00);

  // Scan port, lock state and band gap references.
  assign scan_port_enable_o = st.scan_en;
  assign system_unlocked_o = (st.lock == SCL_UNLOCKED);
  assign converter_ref_enable_o = st.bg[`SCL_BG_ADC_BIT-`SCL_BG_LO];
  assign comparator_ref_enable_o = st.bg[`SCL_BG_CMP_BIT-`SCL_BG_LO];
endmodule
`default_nettype wire

// >>> scl_regs_props.sv
// Checker of bus timing, field decodes and readback of the config bank.
`timescale 1ns/1ns
`default_nettype none
module scl_regs_props (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [15:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic bus_matrix_err_i,
  input wire logic bus_error_exc_o,
  input wire logic [1:0] arbitration_mode_sel_o,
  input wire logic arb_round_robin_o,
  input wire logic [31:0] ram_exec_start_addr_o,
  input wire logic ram_exec_all_o,
  input wire logic system_unlocked_o,
  input wire logic [1:0] bg_hw_set_i,
  input wire logic converter_ref_enable_o
);
  logic rd_done, wr_done, key_any, key2, bg_wr;
  // Completed transfers, split by target.
  assign rd_done = avs_read_i && !avs_waitrequest_o;
  assign wr_done = avs_write_i && !avs_waitrequest_o;
  assign key_any = wr_done && avs_address_i == 16'h3670;
  assign key2 = key_any && avs_writedata_i == 32'h5566_99AA;
  assign bg_wr = wr_done && avs_address_i[15:4] == 12'h230;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  a_one_wait: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("access did not complete");
  a_hole_zero: assert property (rd_done && avs_address_i == 16'h3000 |-> avs_readdata_o == 0)
    else $error("unmapped read not zero");
  a_cfg_fixed: assert property (rd_done && avs_address_i == 16'h3640 |-> (avs_readdata_o & 32'hF400_FFF7) == 32'h3)
    else $error("config fixed bits wrong");
  a_key_status: assert property (rd_done && avs_address_i == 16'h3670 |-> avs_readdata_o == {31'h0, system_unlocked_o})
    else $error("unlock readback wrong");
  a_bg_unused: assert property (rd_done && avs_address_i == 16'h2300 |-> avs_readdata_o[31:3] == 0 && !avs_readdata_o[0])
    else $error("band gap spare bits set");
  a_arb_decode: assert property (arb_round_robin_o == (arbitration_mode_sel_o == 2'h2))
    else $error("round robin decode wrong");
  a_exec_span: assert property (ram_exec_start_addr_o[31:18] == 14'h2800 && ram_exec_start_addr_o[9:0] == 0 && ram_exec_all_o == (ram_exec_start_addr_o == 32'hA000_0000))
    else $error("exec start out of range");
  a_exc_cause: assert property (bus_error_exc_o |-> $past(bus_matrix_err_i))
    else $error("exception without bus error");
  a_unlock_cause: assert property ($rose(system_unlocked_o) |-> $past(key2))
    else $error("unlocked without second key");
  a_lock_cause: assert property ($fell(system_unlocked_o) |-> $past(key_any))
    else $error("locked without key write");
  a_conv_cause: assert property ($rose(converter_ref_enable_o) |-> $past(bg_wr) || $past(bg_hw_set_i[1]))
    else $error("converter ref rose uncaused");
endmodule
bind scl_regs scl_regs_props u_props (.sys_clk_i, .sys_rst_i, .avs_address_i, .avs_read_i,
  .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .bus_matrix_err_i,
  .bus_error_exc_o, .arbitration_mode_sel_o, .arb_round_robin_o, .ram_exec_start_addr_o,
  .ram_exec_all_o, .system_unlocked_o, .bg_hw_set_i, .converter_ref_enable_o);
`default_nettype wire

// >>> test_system_config_lock_regs.sv
// Self-checking bench of the config, identification, unlock and band gap bank.
`timescale 1ns/1ns
`default_nettype none
module test_system_config_lock_regs;
  localparam logic [3:0] REV = 4'h3; // Arbitrary value.
  localparam logic [27:0] PART = 28'h0AB_CDE1; // Arbitrary value.
  logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [15:0] avs_address_i = 16'h0;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, ram_exec_start_addr_o, d;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic bus_matrix_err_i = 1'b0, scan_port_cfg_i = 1'b1;
  logic [1:0] bg_hw_set_i = 2'h0, bg_hw_clr_i = 2'h0, arbitration_mode_sel_o;
  logic avs_waitrequest_o, irq_o, bus_error_exc_o, arb_fixed_cpu_high_o, arb_fixed_cpu_low_o;
  logic arb_round_robin_o, ram_exec_all_o, scan_port_enable_o, system_unlocked_o;
  logic converter_ref_enable_o, comparator_ref_enable_o;
  logic [15:0] bg_a[4] = '{16'h2304, 16'h2308, 16'h230C, 16'h230C};
  logic [31:0] bg_d[4] = '{32'h4, 32'h4, 32'h6, 32'h2};
  logic [31:0] bg_e[4] = '{32'h2, 32'h6, 32'h0, 32'h2};
  logic [31:0] exp_q[$];
  int err_total = 0, n_checks = 0, seed = 52503;
  scl_regs #(.REV_ID(REV), .PART_ID(PART)) dut_u (.*);
  // Free-running 125 MHz clock.
  always #4 sys_clk_i = ~sys_clk_i;
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Compares a settled output with its expected value.
  task automatic chk_o(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Compares read data with the oldest queued note.
  task automatic chk_rd(input logic [31:0] got);
    n_checks++;
    if (exp_q.size() == 0 || got !== exp_q[0]) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp_q[0]);
    end
    if (exp_q.size() > 0) begin
      void'(exp_q.pop_front());
    end
  endtask
  // One bus transfer, held until waitrequest is sampled low at a rising edge.
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= v;
    avs_write_i <= w;
    avs_read_i <= !w;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    if (avs_waitrequest_o !== 1'b0) begin
      err_total++;
      close_out();
    end else begin
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    bus(1'b1, a, v);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  // Lets registered outputs land before they are compared.
  task automatic settle();
    repeat (2) @(negedge sys_clk_i);
  endtask
  // Watches completed reads at the edge where waitrequest is sampled low.
  always @(posedge sys_clk_i) begin
    if (avs_read_i && avs_waitrequest_o === 1'b0) begin
      chk_rd(avs_readdata_o);
    end
  end
  // Main sequence.
  initial begin
    repeat (8) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    rd(16'h3640, 32'hB);
    wr(16'h3660, 32'hFFFF_FFFF);
    rd(16'h3660, {REV, PART});
    rd(16'h3670, 32'h1);
    rd(16'h2300, 32'h0);
    rd(16'h3000, 32'h0);
    $display("reset test done");
    wr(16'h3670, 32'h0);
    wr(16'h3684, 32'h0);
    wr(16'h3680, 32'h7);
    wr(16'h3640, 32'h0800_0000);
    rd(16'h3640, 32'hB);
    rd(16'h3680, 32'h4);
    chk_o(irq_o, 32'h0);
    wr(16'h3684, 32'h4);
    settle();
    chk_o(irq_o, 32'h1);
    wr(16'h3680, 32'h4);
    settle();
    chk_o(irq_o, 32'h0);
    wr(16'h3670, 32'hAA99_6655);
    wr(16'h3670, 32'h1234);
    wr(16'h3670, 32'h5566_99AA);
    settle();
    chk_o(system_unlocked_o, 32'h0);
    wr(16'h3670, 32'hAA99_6655);
    wr(16'h3670, 32'h5566_99AA);
    settle();
    chk_o(system_unlocked_o, 32'h1);
    $display("lock test done");
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      d[25:24] = i[1:0];
      d[27] = i[0];
      d[23:16] = (i == 0) ? 8'h0 : (i == 3) ? 8'hFF : d[23:16];
      wr(16'h3640, d);
      rd(16'h3640, (d & 32'h0BFF_0008) | 32'h3);
      chk_o({arb_round_robin_o, arb_fixed_cpu_low_o, arb_fixed_cpu_high_o}, (i == 3) ? 0 : 1 << i);
      chk_o(arbitration_mode_sel_o, i[1:0]);
      chk_o(ram_exec_start_addr_o, 32'hA000_0000 + {d[23:16], 10'h0});
      chk_o(ram_exec_all_o, d[23:16] == 8'h0);
      chk_o(scan_port_enable_o, d[3]);
      @(posedge sys_clk_i);
      bus_matrix_err_i <= 1'b1;
      @(posedge sys_clk_i);
      bus_matrix_err_i <= 1'b0;
      @(negedge sys_clk_i);
      chk_o(bus_error_exc_o, !d[27]);
    end
    $display("config test done");
    wr(16'h2300, 32'hFFFF_FFFF);
    rd(16'h2300, 32'h6);
    // A write without the low byte lane must leave the enables alone.
    avs_byteenable_i <= 4'hE;
    wr(16'h2300, 32'h0);
    avs_byteenable_i <= 4'hF;
    rd(16'h2300, 32'h6);
    for (int i = 0; i < 4; i++) begin
      wr(bg_a[i], bg_d[i]);
      settle();
      chk_o({converter_ref_enable_o, comparator_ref_enable_o, 1'b0}, bg_e[i]);
    end
    rd(16'h2308, 32'h0);
    @(posedge sys_clk_i);
    bg_hw_set_i <= 2'h2;
    @(posedge sys_clk_i);
    bg_hw_set_i <= 2'h0;
    settle();
    chk_o({converter_ref_enable_o, comparator_ref_enable_o}, 32'h3);
    @(posedge sys_clk_i);
    bg_hw_clr_i <= 2'h3;
    @(posedge sys_clk_i);
    bg_hw_clr_i <= 2'h0;
    settle();
    chk_o({converter_ref_enable_o, comparator_ref_enable_o}, 32'h0);
    $display("band gap test done");
    close_out();
  end
endmodule
`default_nettype wire
